// File: logic/bbm_matcher.sv
// bus cycle break matcher with avalon register slave
`timescale 1ns/1ps
// Overview of operation
// - fetch with write condition never matches
// - odd fetch address misses normal even fetches
// - word condition on odd address never matches
// - dma instruction fetch condition never matches
// - full agreement of conditions requests break
// - fetch match latched, later condition register change ignored
// - non-delayed branch: two overrun fetches, destination
// - delayed branch: slot, one overrun, destination
// - fetch break only after execution confirmed
// - overrun fetch satisfies enabled data condition
// - higher exception in decode drops pending break
// - first non-delay branch destination never breaks
// - two-bit select sets trigger width
// - new match restarts full trigger pulse
// - overrun fetch match triggers, no break
// - data and dma matches trigger like breaks
// - disable bit keeps trigger, blocks break
// - reset enters standby; clear before configuring
// - trigger width scales with clock ratio
// - ratio change alters running pulse at once
// - direction codes none, read, write, both
// - size codes ignore, byte, word, longword
// - disable bit resets to zero, enabled
// - break request presented at level fifteen
module bbm_matcher (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // avalon-mm register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // internal bus cycle monitor
  input wire logic cyc_valid,
  input wire logic [31:0] cyc_addr,
  input wire logic cyc_dma,
  input wire logic cyc_fetch,
  input wire logic cyc_write,
  input wire logic [1:0] cyc_size,
  input wire logic cyc_dual_fetch,
  input wire logic cyc_overrun,
  input wire logic cyc_branch_dest,
  // cpu pipeline events
  input wire logic fetch_exec_ok,
  input wire logic exc_accept,
  // interrupt controller
  output logic break_irq_req,
  output logic [3:0] break_irq_level,
  input wire logic break_irq_ack,
  // clock ratio strap and trigger pin
  input wire logic clk_ratio_eight,
  output logic break_trigger_out
);
  // configuration registers
  logic [15:0] break_addr_high_reg;
  logic [15:0] break_addr_low_reg;
  logic [15:0] break_cycle_type_reg;
  logic [15:0] break_control_reg;
  logic standby; // module standby
  logic [15:0] next_addr_hi, next_addr_lo, next_cyc_type, next_ctrl;
  logic next_standby;
  // bus slave state
  logic ack; // answer cycle
  logic next_ack;
  logic [31:0] next_readdata;
  // ratio synchroniser
  logic ratio_meta, ratio_sync;
  // fetch tracker and request
  bbm_pkg::bbm_fb_state_t fb_state, next_fb_state;
  logic next_irq_req;
  // condition fields
  logic [31:0] brk_addr;
  logic [1:0] cp, id, rw, sz;
  logic irq_dis;
  // match terms
  logic addr_hit, size_ok, word_odd, master_ok, dir_ok;
  logic fetch_hit, data_hit, overrun_data_hit;
  logic trig_fire, irq_now, fetch_arm, irq_set;
  logic req; // bus request present

  // merge a 16-bit register with the low byte lanes
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
    lane_merge = old;
    if (be[0]) begin
      lane_merge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      lane_merge[15:8] = wd[15:8];
    end
  endfunction : lane_merge

  // field decode
  assign brk_addr = {break_addr_high_reg, break_addr_low_reg};
  assign cp = break_cycle_type_reg[bbm_pkg::CYC_CP_POS +: 2];
  assign id = break_cycle_type_reg[bbm_pkg::CYC_ID_POS +: 2];
  assign rw = break_cycle_type_reg[bbm_pkg::CYC_RW_POS +: 2];
  assign sz = break_cycle_type_reg[bbm_pkg::CYC_SZ_POS +: 2];
  assign irq_dis = break_control_reg[bbm_pkg::CTRL_DIS_BIT];
  assign req = avs_read | avs_write;
  // one wait state on every access
  assign avs_waitrequest = req & ~ack;
  // fixed priority level
  assign break_irq_level = bbm_pkg::BREAK_LEVEL;

  // match evaluation against the live cycle
  always_comb begin
    // second instruction of a dual fetch sits two bytes up
    addr_hit = (cyc_addr == brk_addr) ||
               (cyc_fetch && cyc_dual_fetch &&
                ((cyc_addr + 32'h0000_0002) == brk_addr));
    // fetches count as word size
    size_ok = (sz == bbm_pkg::SEL_NONE) ||
              (sz == (cyc_fetch ? bbm_pkg::SZ_WORD : cyc_size));
    // words only ever sit on even addresses
    word_odd = (sz == bbm_pkg::SZ_WORD) && brk_addr[0];
    master_ok = cyc_dma ? cp[1] : cp[0];
    // bit one selects write, bit zero read
    dir_ok = cyc_write ? rw[1] : rw[0];
    // cpu fetch: read only, never dma
    fetch_hit = cyc_valid && !standby && cyc_fetch && addr_hit &&
                cp[0] && !cyc_dma && id[0] && rw[0] &&
                size_ok;
    // data access of either master
    data_hit = cyc_valid && !standby && !cyc_fetch && addr_hit &&
               master_ok && id[1] && dir_ok && size_ok &&
               !word_odd;
    // overrun fetch also counts as a data access
    overrun_data_hit = cyc_valid && !standby && cyc_fetch &&
                       cyc_overrun && addr_hit && master_ok && id[1] &&
                       rw[0] && size_ok;
    // trigger on every match, overruns included
    trig_fire = fetch_hit || data_hit || overrun_data_hit;
    irq_now = data_hit || overrun_data_hit;
    // only real, non-destination fetches wait for execution
    fetch_arm = fetch_hit && !cyc_overrun &&
                !cyc_branch_dest;
  end

  // fetch break tracker, decided at fetch time
  always_comb begin
    next_fb_state = fb_state;
    irq_set = irq_now;
    case (fb_state)
      bbm_pkg::FB_IDLE: begin
        // latch now; later condition writes do not matter
        if (fetch_arm) begin
          next_fb_state = bbm_pkg::FB_PENDING;
        end
      end
      bbm_pkg::FB_PENDING: begin
        if (standby) begin
          next_fb_state = bbm_pkg::FB_IDLE;
        end else if (exc_accept) begin
          // higher exception in decode loses the break
          next_fb_state = bbm_pkg::FB_IDLE;
        end else if (fetch_exec_ok) begin
          // execution confirmed: break now
          next_fb_state = bbm_pkg::FB_IDLE;
          irq_set = 1'b1;
        end
      end
      default: begin
        next_fb_state = bbm_pkg::FB_IDLE;
      end
    endcase
    // disable bit blocks only the request
    irq_set = irq_set && !irq_dis && !standby;
    // set wins over acknowledge
    next_irq_req = irq_set || (break_irq_req && !break_irq_ack &&
                               !standby);
  end

  // tracker and request registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fb_state <= bbm_pkg::FB_IDLE;
      break_irq_req <= 1'b0;
    end else begin
      fb_state <= next_fb_state;
      break_irq_req <= next_irq_req;
    end
  end

  // register writes and read mux
  always_comb begin
    next_addr_hi = break_addr_high_reg;
    next_addr_lo = break_addr_low_reg;
    next_cyc_type = break_cycle_type_reg;
    next_ctrl = break_control_reg;
    next_standby = standby;
    next_ack = req & ~ack;
    next_readdata = avs_readdata;
    if (avs_write && ack) begin
      // standby register always writable
      if (avs_address == bbm_pkg::OFS_STANDBY && avs_byteenable[0]) begin
        next_standby = avs_writedata[0];
      end
      // condition registers ignore writes in standby
      if (!standby) begin
        case (avs_address)
          bbm_pkg::OFS_ADDR_HI: begin
            next_addr_hi = lane_merge(break_addr_high_reg, avs_writedata,
                                      avs_byteenable);
          end
          bbm_pkg::OFS_ADDR_LO: begin
            next_addr_lo = lane_merge(break_addr_low_reg, avs_writedata,
                                      avs_byteenable);
          end
          bbm_pkg::OFS_CYC_TYPE: begin
            next_cyc_type = lane_merge(break_cycle_type_reg,
                                       avs_writedata, avs_byteenable);
          end
          bbm_pkg::OFS_CTRL: begin
            next_ctrl = lane_merge(break_control_reg, avs_writedata,
                                   avs_byteenable) & bbm_pkg::CTRL_MASK;
          end
          default: begin
            next_ctrl = break_control_reg;
          end
        endcase
      end
    end
    // standby holds configuration at reset values
    if (next_standby) begin
      next_addr_hi = bbm_pkg::RST_ADDR;
      next_addr_lo = bbm_pkg::RST_ADDR;
      next_cyc_type = bbm_pkg::RST_CYC_TYPE;
      next_ctrl = bbm_pkg::RST_CTRL;
    end
    // read data captured in the wait cycle
    if (avs_read && !ack) begin
      case (avs_address)
        bbm_pkg::OFS_ADDR_HI: next_readdata = {16'h0000,
                                               break_addr_high_reg};
        bbm_pkg::OFS_ADDR_LO: next_readdata = {16'h0000,
                                               break_addr_low_reg};
        bbm_pkg::OFS_CYC_TYPE: next_readdata = {16'h0000,
                                                break_cycle_type_reg};
        bbm_pkg::OFS_CTRL: next_readdata = {16'h0000, break_control_reg};
        bbm_pkg::OFS_STANDBY: next_readdata = {31'h0, standby};
        // live block state
        bbm_pkg::OFS_STATUS: next_readdata = {27'h0, ratio_sync,
            ~break_trigger_out, break_irq_req,
            fb_state == bbm_pkg::FB_PENDING, standby};
        // unmapped reads as zero
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // register file and slave registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      break_addr_high_reg <= bbm_pkg::RST_ADDR;
      break_addr_low_reg <= bbm_pkg::RST_ADDR;
      break_cycle_type_reg <= bbm_pkg::RST_CYC_TYPE;
      break_control_reg <= bbm_pkg::RST_CTRL;
      standby <= bbm_pkg::RST_STANDBY;
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      break_addr_high_reg <= next_addr_hi;
      break_addr_low_reg <= next_addr_lo;
      break_cycle_type_reg <= next_cyc_type;
      break_control_reg <= next_ctrl;
      standby <= next_standby;
      ack <= next_ack;
      avs_readdata <= next_readdata;
    end
  end

  // two-stage synchroniser for the ratio strap
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ratio_meta <= 1'b0;
      ratio_sync <= 1'b0;
    end else begin
      ratio_meta <= clk_ratio_eight;
      ratio_sync <= ratio_meta;
    end
  end

  // trigger pulse output
  bbm_trig_pulse u_trig (
    .ref_clk(ref_clk),
    .rst(rst),
    .fire(trig_fire),
    .standby(standby),
    .width_sel(break_control_reg[bbm_pkg::CTRL_WSEL_POS +: 2]),
    .ratio_eight(ratio_sync),
    .trig_n(break_trigger_out)
  );

  a_fetch_write_none: assert property (
    @(posedge ref_clk) disable iff (rst)
    (cyc_valid && cyc_fetch && rw == bbm_pkg::RW_WRITE &&
     id == bbm_pkg::ID_FETCH) |-> !trig_fire)
    else $error("fetch matched a write-only condition");
  a_dma_fetch_none: assert property (
    @(posedge ref_clk) disable iff (rst)
    (cyc_valid && cyc_dma && cp == bbm_pkg::CP_DMA &&
     id == bbm_pkg::ID_FETCH) |-> !trig_fire)
    else $error("dma fetch condition matched");
  a_word_odd_none: assert property (
    @(posedge ref_clk) disable iff (rst)
    (sz == bbm_pkg::SZ_WORD && brk_addr[0] && !cyc_fetch) |-> !data_hit)
    else $error("word condition on odd address matched");
  a_data_irq_set: assert property (
    @(posedge ref_clk) disable iff (rst)
    (data_hit && !irq_dis) |=> (break_irq_req && !break_trigger_out))
    else $error("data match missed request or trigger");
  a_overrun_no_irq: assert property (
    @(posedge ref_clk) disable iff (rst)
    (fetch_hit && cyc_overrun && !id[1] && !break_irq_req &&
     fb_state == bbm_pkg::FB_IDLE) |=> (!break_irq_req &&
     !break_trigger_out && fb_state == bbm_pkg::FB_IDLE))
    else $error("overrun fetch raised a break");
  a_disable_blocks: assert property (
    @(posedge ref_clk) disable iff (rst)
    (irq_dis && !break_irq_req) |=> !break_irq_req)
    else $error("break raised while disabled");
  a_exc_drops: assert property (
    @(posedge ref_clk) disable iff (rst)
    (fb_state == bbm_pkg::FB_PENDING && exc_accept && !irq_now &&
     !break_irq_req) |=> (fb_state == bbm_pkg::FB_IDLE && !break_irq_req))
    else $error("pending break survived exception");
  a_confirm_break: assert property (
    @(posedge ref_clk) disable iff (rst)
    (fb_state == bbm_pkg::FB_PENDING && fetch_exec_ok && !exc_accept &&
     !standby && !irq_dis) |=> break_irq_req)
    else $error("confirmed fetch break not raised");
  a_level_fixed: assert property (
    @(posedge ref_clk) disable iff (rst)
    break_irq_req |-> break_irq_level == 4'hF)
    else $error("break level not fifteen");
  a_reset_standby: assert property (@(posedge ref_clk)
    rst |=> (standby && break_trigger_out && !break_irq_req))
    else $error("not in standby after reset");
endmodule : bbm_matcher

// File: common/bbm_pkg.sv
// constants, encodings and states shared by the bus cycle break matcher
package bbm_pkg;
  // register byte offsets on the avalon slave
  localparam logic [4:0] OFS_ADDR_HI = 5'h00;
  localparam logic [4:0] OFS_ADDR_LO = 5'h04;
  localparam logic [4:0] OFS_CYC_TYPE = 5'h08;
  localparam logic [4:0] OFS_CTRL = 5'h0C;
  localparam logic [4:0] OFS_STANDBY = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  // values after reset
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [15:0] RST_CYC_TYPE = 16'h0000;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic RST_STANDBY = 1'b1;
  // field positions in the cycle type register
  localparam int unsigned CYC_CP_POS = 6;
  localparam int unsigned CYC_ID_POS = 4;
  localparam int unsigned CYC_RW_POS = 2;
  localparam int unsigned CYC_SZ_POS = 0;
  // field positions in the control register
  localparam int unsigned CTRL_DIS_BIT = 0;
  localparam int unsigned CTRL_WSEL_POS = 1;
  // writable mask of the control register
  localparam logic [15:0] CTRL_MASK = 16'h0007;
  // two-bit selector encodings
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] RW_READ = 2'h1;
  localparam logic [1:0] RW_WRITE = 2'h2;
  localparam logic [1:0] ID_FETCH = 2'h1;
  localparam logic [1:0] CP_DMA = 2'h2;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LONG = 2'h3;
  // priority level presented with the break request
  localparam logic [3:0] BREAK_LEVEL = 4'hF;
  // trigger width in cycles at ratio four, one entry per select code
  localparam logic [5:0] TRIG_W0 = 6'h02;
  localparam logic [5:0] TRIG_W1 = 6'h04;
  localparam logic [5:0] TRIG_W2 = 6'h08;
  localparam logic [5:0] TRIG_W3 = 6'h10;
  // pulse counter value on the first low cycle
  localparam logic [5:0] TRIG_CNT_START = 6'h01;
  // fetch break tracker states
  typedef enum logic {FB_IDLE, FB_PENDING} bbm_fb_state_t;
endpackage : bbm_pkg

// File: logic/bbm_trig_pulse.sv
// trigger pulse generator with retrigger and ratio scaled width
`timescale 1ns/1ps
module bbm_trig_pulse (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic fire,
  input wire logic standby,
  input wire logic [1:0] width_sel,
  input wire logic ratio_eight,
  // active low pulse pin
  output logic trig_n
);
  logic active; // pulse in progress
  logic [5:0] cnt; // low cycles elapsed
  logic next_active;
  logic [5:0] next_cnt;
  logic [5:0] width; // live width in cycles

  // width lookup, doubled at ratio eight
  function automatic logic [5:0] width_of(input logic [1:0] sel,
                                          input logic eight);
    logic [5:0] base;
    case (sel)
      2'h0: base = bbm_pkg::TRIG_W0;
      2'h1: base = bbm_pkg::TRIG_W1;
      2'h2: base = bbm_pkg::TRIG_W2;
      default: base = bbm_pkg::TRIG_W3;
    endcase
    width_of = eight ? {base[4:0], 1'b0} : base;
  endfunction : width_of

  // width follows select and ratio every cycle
  assign width = width_of(width_sel, ratio_eight);

  // next pulse state
  always_comb begin
    next_active = active;
    next_cnt = cnt;
    if (standby) begin
      // standby clears the counter
      next_active = 1'b0;
      next_cnt = 6'h00;
    end else if (fire) begin
      // a new match restarts a full pulse
      next_active = 1'b1;
      next_cnt = bbm_pkg::TRIG_CNT_START;
    end else if (active) begin
      // ends once the live width is reached
      if (cnt >= width) begin
        next_active = 1'b0;
        next_cnt = 6'h00;
      end else begin
        next_cnt = cnt + 6'h01;
      end
    end
  end

  // pulse registers, pin idles high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active <= 1'b0;
      cnt <= 6'h00;
      trig_n <= 1'b1;
    end else begin
      active <= next_active;
      cnt <= next_cnt;
      trig_n <= ~next_active;
    end
  end

  a_pulse_restart: assert property (
    @(posedge ref_clk) disable iff (rst)
    (fire && !standby) |=> (!trig_n && cnt == bbm_pkg::TRIG_CNT_START))
    else $error("trigger did not restart on match");
  a_pulse_idle: assert property (
    @(posedge ref_clk) disable iff (rst)
    (standby || (!active && !fire)) |=> trig_n)
    else $error("trigger low while idle or in standby");
endmodule : bbm_trig_pulse

// File: bench/bbm_bus_model.sv
// model of cpu and dma bus cycles, pipeline events and irq controller
`timescale 1ns/1ps
module bbm_bus_model (
  // clock
  input wire logic ref_clk,
  // bus cycle monitor
  output logic cyc_valid,
  output logic [31:0] cyc_addr,
  output logic cyc_dma,
  output logic cyc_fetch,
  output logic cyc_write,
  output logic [1:0] cyc_size,
  output logic cyc_dual_fetch,
  output logic cyc_overrun,
  output logic cyc_branch_dest,
  // pipeline events
  output logic fetch_exec_ok,
  output logic exc_accept,
  // interrupt controller
  input wire logic break_irq_req,
  output logic break_irq_ack
);
  int ack_dly = 0; // wait before the controller accepts
  int cnt = 0; // cycles the request has waited
  initial begin
    {cyc_valid, cyc_dma, cyc_fetch, cyc_write, cyc_dual_fetch} = 5'h00;
    {cyc_overrun, cyc_branch_dest, fetch_exec_ok, exc_accept} = 4'h0;
    {cyc_addr, cyc_size} = 34'h0;
  end
  // controller accepts a pending request after ack_dly cycles
  always @(posedge ref_clk) begin
    if (break_irq_req === 1'b1 && !break_irq_ack && cnt >= ack_dly) begin
      break_irq_ack <= 1'b1;
      cnt <= 0;
    end else begin
      break_irq_ack <= 1'b0;
      cnt <= (break_irq_req === 1'b1) ? cnt + 1 : 0;
    end
  end
  // one bus cycle; f is dma, fetch, write, dual; k is overrun, dest
  task issue(input logic [31:0] a, input logic [3:0] f,
             input logic [1:0] sz, input logic [1:0] k);
    @(posedge ref_clk);
    cyc_valid <= 1'b1;
    cyc_addr <= a;
    {cyc_dma, cyc_fetch, cyc_write, cyc_dual_fetch} <= f;
    {cyc_overrun, cyc_branch_dest} <= k;
    cyc_size <= sz;
    @(posedge ref_clk);
    // bus released: address no longer holds the old value
    cyc_valid <= 1'b0;
    cyc_addr <= ~a;
    cyc_size <= ~sz;
  endtask : issue
  // one pulse of exception accept or execution confirm
  task pulse(input logic exc);
    @(posedge ref_clk);
    if (exc) exc_accept <= 1'b1;
    else fetch_exec_ok <= 1'b1;
    @(posedge ref_clk);
    exc_accept <= 1'b0;
    fetch_exec_ok <= 1'b0;
  endtask : pulse
endmodule : bbm_bus_model

// File: bench/bbm_matcher_tb.sv
// self-checking testbench of the bus cycle break matcher
`timescale 1ns/1ps
module bbm_matcher_tb;
  logic ref_clk = 1'b0; // 100 mhz clock
  logic rst = 1'b1; // synchronous reset
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cyc_valid, cyc_dma, cyc_fetch, cyc_write, cyc_dual_fetch;
  logic cyc_overrun, cyc_branch_dest, fetch_exec_ok, exc_accept;
  logic [31:0] cyc_addr;
  logic [1:0] cyc_size;
  logic break_irq_req, break_irq_ack, break_trigger_out;
  logic [3:0] break_irq_level;
  logic clk_ratio_eight = 1'b0; // clock ratio strap
  int fails = 0;
  int n_compared = 0;
  int lv, sel;
  logic [15:0] t;
  logic [31:0] ca, a;
  logic [3:0] f;
  logic [1:0] sz;
  bit h;
  always #5 ref_clk = ~ref_clk;
  bbm_matcher dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_dma(cyc_dma),
    .cyc_fetch(cyc_fetch), .cyc_write(cyc_write), .cyc_size(cyc_size),
    .cyc_dual_fetch(cyc_dual_fetch), .cyc_overrun(cyc_overrun),
    .cyc_branch_dest(cyc_branch_dest), .fetch_exec_ok(fetch_exec_ok),
    .exc_accept(exc_accept), .break_irq_req(break_irq_req),
    .break_irq_level(break_irq_level), .break_irq_ack(break_irq_ack),
    .clk_ratio_eight(clk_ratio_eight),
    .break_trigger_out(break_trigger_out));
  bbm_bus_model far (.ref_clk(ref_clk), .cyc_valid(cyc_valid),
    .cyc_addr(cyc_addr), .cyc_dma(cyc_dma), .cyc_fetch(cyc_fetch),
    .cyc_write(cyc_write), .cyc_size(cyc_size),
    .cyc_dual_fetch(cyc_dual_fetch), .cyc_overrun(cyc_overrun),
    .cyc_branch_dest(cyc_branch_dest), .fetch_exec_ok(fetch_exec_ok),
    .exc_accept(exc_accept), .break_irq_req(break_irq_req),
    .break_irq_ack(break_irq_ack));
  // verdict and end of run
  task wrap_up;
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // one comparison
  task chk(input bit ok, input string m);
    n_compared++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  // expected low cycles of the trigger
  function automatic int wexp(input int s, input bit x8);
    int w;
    w = (s == 0) ? 2 : (s == 1) ? 4 : (s == 2) ? 8 : 16;
    return x8 ? 2 * w : w;
  endfunction : wexp
  // expected match of a data cycle
  function automatic bit hit(input logic [15:0] t, input logic [31:0] c,
      input logic [31:0] a, input logic [3:0] f, input logic [1:0] s);
    return a == c && t[6 + f[3]] && t[5] && t[2 + f[1]] &&
      (t[1:0] == 2'h0 || t[1:0] == s);
  endfunction : hit
  // one avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [4:0] ad, input logic [15:0] d,
           output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= ad;
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= !w;
    // sampled at the rising edge, before that edge's updates
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    chk(avs_waitrequest === 1'b0, "no bus answer");
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // read and compare a register
  task rd(input logic [4:0] ad, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, ad, 16'h0000, q);
    chk(q === e, "register read");
  endtask : rd
  // write a register
  task wr(input logic [4:0] ad, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask : wr
  // trigger low cycles and request seen over a window
  task measure(output int l, output bit i);
    l = 0;
    i = 0;
    repeat (40) begin
      @(negedge ref_clk);
      l += (break_trigger_out === 1'b0);
      i |= (break_irq_req === 1'b1);
      chk(break_irq_level === 4'hF, "break level");
    end
  endtask : measure
  // configure, issue, optional events, compare width and request
  task run(input logic [31:0] c, input logic [15:0] t, input logic [15:0] r,
      input logic [31:0] a, input logic [3:0] f, input logic [1:0] s,
      input logic [1:0] k, input int ev, input int el, input bit ei);
    int l, l2;
    bit i, i2;
    wr(bbm_pkg::OFS_ADDR_HI, c[31:16]);
    wr(bbm_pkg::OFS_ADDR_LO, c[15:0]);
    wr(bbm_pkg::OFS_CYC_TYPE, t);
    wr(bbm_pkg::OFS_CTRL, r);
    far.issue(a, f, s, k);
    if (ev == 3) far.issue(a, f, s, k);
    measure(l, i);
    if (ev == 1 || ev == 2 || ev == 4) begin
      chk(i == 0, "request before confirm");
      // conditions change while the fetch break waits
      if (ev == 4) wr(bbm_pkg::OFS_CYC_TYPE, 16'h0000);
      if (ev == 2) far.pulse(1'b1);
      far.pulse(1'b0);
      measure(l2, i2);
      i = i2;
    end
    chk(l == el, "trigger width");
    chk(i == ei, "break request");
  endtask : run
  initial begin
    #200000;
    fails++;
    wrap_up;
  end
  initial begin
    void'($urandom(58401));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(bbm_pkg::OFS_STATUS, 32'h1);
    rd(bbm_pkg::OFS_CTRL, 32'h0);
    wr(bbm_pkg::OFS_ADDR_LO, 16'h1234);
    rd(bbm_pkg::OFS_ADDR_LO, 32'h0);
    rd(5'h18, 32'h0);
    wr(bbm_pkg::OFS_STANDBY, 16'h0000);
    rd(bbm_pkg::OFS_STANDBY, 32'h0);
    $display("test registers done");
    run(32'h15389C, 16'h0058, 0, 32'h15389C, 4'h4, 2, 0, 1, 0, 0);
    run(32'h30147, 16'h0054, 0, 32'h30146, 4'h5, 2, 0, 1, 0, 0);
    run(32'h123456, 16'h006A, 0, 32'h123456, 4'h2, 2, 0, 0, 2, 1);
    run(32'hA80391, 16'h0066, 0, 32'hA80391, 4'h0, 2, 0, 0, 0, 0);
    run(32'h76BCDC, 16'h00A7, 0, 32'h76BCDC, 4'h8, 3, 0, 0, 2, 1);
    run(32'h2345C8, 16'h0094, 0, 32'h2345C8, 4'hC, 2, 0, 0, 0, 0);
    run(32'h123456, 16'h0062, 0, 32'h123456, 4'h2, 2, 0, 0, 0, 0);
    run(32'h123456, 16'h006A, 1, 32'h123456, 4'h2, 2, 0, 0, 2, 0);
    run(32'h123456, 16'h006A, 2, 32'h123456, 4'h2, 2, 0, 3, 4, 1);
    $display("test data cycles done");
    run(32'h404, 16'h0054, 0, 32'h404, 4'h4, 2, 0, 1, 2, 1);
    run(32'h406, 16'h0054, 0, 32'h404, 4'h5, 2, 0, 4, 2, 1);
    run(32'h404, 16'h0054, 0, 32'h404, 4'h4, 2, 2, 1, 2, 0);
    run(32'h404, 16'h0054, 0, 32'h404, 4'h4, 2, 1, 1, 2, 0);
    run(32'h404, 16'h0054, 0, 32'h404, 4'h4, 2, 0, 2, 2, 0);
    run(32'h404, 16'h0074, 0, 32'h404, 4'h4, 2, 2, 0, 2, 1);
    $display("test fetch cycles done");
    far.ack_dly = 3;
    for (lv = 0; lv < 8; lv++) begin
      @(posedge ref_clk);
      clk_ratio_eight <= lv[2];
      run(32'h123456, 16'h006A, {13'h0000, lv[1:0], 1'b0}, 32'h123456, 4'h2,
          2, 0, 0, wexp(lv[1:0], lv[2]), 1);
    end
    @(posedge ref_clk);
    clk_ratio_eight <= 1'b0;
    far.ack_dly = 0;
    // ratio rises while a widest pulse runs
    fork
      run(32'h123456, 16'h006A, 16'h0006, 32'h123456, 4'h2, 2, 0, 0,
          wexp(3, 1), 1);
      begin
        repeat (20) @(posedge ref_clk);
        clk_ratio_eight <= 1'b1;
      end
    join
    @(posedge ref_clk);
    clk_ratio_eight <= 1'b0;
    $display("test trigger widths done");
    repeat (24) begin
      ca = $urandom & 32'hFFFFFFFE;
      t = 16'($urandom_range(0, 255));
      sel = $urandom_range(0, 3);
      a = $urandom_range(0, 1) ? ca : $urandom;
      f = {1'($urandom), 1'b0, 1'($urandom), 1'b0};
      sz = 2'($urandom_range(1, 3));
      h = hit(t, ca, a, f, sz);
      run(ca, t, 16'(sel << 1), a, f, sz, 0, 0, h ? wexp(sel, 0) : 0,
          h);
    end
    $display("test random cycles done");
    wrap_up;
  end
endmodule : bbm_matcher_tb
